/* tpwm_pkg.sv */
// Constants shared by the dual 8-bit PWM / cascaded 16-bit interval timer.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package tpwm_pkg;

  // Register byte offsets.
  localparam logic [4:0] ADDR_CTRL_LO = 5'h00;
  localparam logic [4:0] ADDR_CTRL_HI = 5'h04;
  localparam logic [4:0] ADDR_DUTY_LO = 5'h08;
  localparam logic [4:0] ADDR_DUTY_HI = 5'h0C;
  localparam logic [4:0] ADDR_PCMP_LO = 5'h10;
  localparam logic [4:0] ADDR_PCMP_HI = 5'h14;
  localparam logic [4:0] ADDR_STATUS = 5'h18;
  localparam logic [4:0] ADDR_POWER = 5'h1C;

  // Timer control register fields.
  localparam int CTRL_FF_BIT = 7;
  localparam int CTRL_CLK_LSB = 4;
  localparam int CTRL_CLK_MSB = 6;
  localparam int CTRL_START_BIT = 3;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_MSB = 2;

  // Operating modes.
  localparam logic [2:0] MODE_PWM8 = 3'h2;
  localparam logic [2:0] MODE_TIMER16 = 3'h4;

  // Source clock selections.
  localparam logic [2:0] CLK_DIV11_OR_LS8 = 3'h0;
  localparam logic [2:0] CLK_DIV7 = 3'h1;
  localparam logic [2:0] CLK_DIV5 = 3'h2;
  localparam logic [2:0] CLK_DIV3 = 3'h3;
  localparam logic [2:0] CLK_LS = 3'h4;
  localparam logic [2:0] CLK_HALF = 3'h5;
  localparam logic [2:0] CLK_FULL = 3'h6;

  // Prescaler tap positions (most significant bit of each all-ones test).
  localparam int PRE_W = 11;
  localparam int DIV11_MSB = 10;
  localparam int DIV7_MSB = 6;
  localparam int DIV5_MSB = 4;
  localparam int DIV3_MSB = 2;
  localparam int LS_DIV_W = 3;

  // Power register fields.
  localparam int PWR_DV_BIT = 0;
  localparam int PWR_SLOW_BIT = 1;

  // Status register fields.
  localparam int STAT_CNT_LO_LSB = 0;
  localparam int STAT_CNT_HI_LSB = 8;
  localparam int STAT_FF_LO_BIT = 16;
  localparam int STAT_FF_HI_BIT = 17;

  // Counter limits and reset values.
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [7:0] PCMP_RESET = 8'h00;
  localparam logic [1:0] PWR_RESET = 2'h0;
  localparam logic [1:0] PIN_RESET = 2'h3;

endpackage

/* tpwm_timer.sv */
// Two cascadable 8-bit up-counters: 8-bit PWM on each, or one 16-bit interval timer.
// Assumes an Avalon-MM master on core_clk and a low-speed tick synchronous to core_clk.
`timescale 1ns/1ps

// Functional notes
// R1 - PWM8 mode counts up on the selected internal clock, eight-bit resolution.
// R2 - Counter equal to active duty inverts the flip-flop; counting continues.
// R3 - Overflow inverts the flip-flop again, clears counter, pulses timer interrupt.
// R4 - Flip-flop takes its control-bit initial value; reset clears it to zero.
// R5 - PWM pin always drives the inverse of the flip-flop.
// R6 - Duty written while running waits in a buffer until the next overflow.
// R7 - Duty written while stopped becomes active right after the write.
// R8 - Reading duty during PWM returns the active value, not the buffered one.
// R9 - Software writes duty right after an interrupt; collisions may misbehave.
// R10 - Stopping the timer holds the PWM pin at its current level.
// R11 - Software clears start before changing the initial-value bit, separately.
// R12 - Software stops the timer before entering stop power mode.
// R13 - PWM8 clock: div11 or low/8, div7, div5, div3, low, half, full.
// R14 - Software sets the port output latch to one for the pin.
// R15 - Timer16 cascades counters; 16-bit match pulses upper irq and clears count.
// R16 - Software writes compare low byte first, then high byte, never one alone.
// R17 - Software keeps the initial-value bit zero in timer mode.
// R18 - Timer16 compare is unbuffered and used immediately after a write.
// R19 - Software avoids changing the compare value while the timer runs.
// R20 - Timer16 clock only: div11 or low/8, div7, div5, div3.
// R21 - Timer16 source clock comes from the lower timer's clock select field.
// R22 - PWM8 period is 256 counts, wrapping from maximum to zero.
module tpwm_timer
  import tpwm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic low_speed_tick,
  output logic [1:0] pwm_out_pin,
  output logic [1:0] timer_irq
);

  // Bus and register state.
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0][7:0] ctrl_q, ctrl_d;
  logic [1:0][7:0] duty_buf_q, duty_buf_d;
  logic [7:0] pcmp_lo_q, pcmp_lo_d;
  logic [7:0] pcmp_hi_q, pcmp_hi_d;
  logic [1:0] pwr_q, pwr_d;

  // Counting state.
  logic [PRE_W-1:0] pre_q, pre_d;
  logic [LS_DIV_W-1:0] ls_div_q, ls_div_d;
  logic [1:0][7:0] cnt_q, cnt_d;
  logic [1:0][7:0] duty_act_q, duty_act_d;
  logic [1:0] ff_q, ff_d;
  logic [1:0] irq_q, irq_d;
  logic [1:0] pin_q, pin_d;

  // Decoded strobes and run conditions.
  logic wr_lane;
  logic [1:0] wr_ctrl;
  logic [1:0] wr_duty;
  logic [7:0] wr_byte;
  logic [1:0] pwm_run;
  logic [1:0] tick;
  logic run16;
  logic tick16;
  logic ls8_tick;

  // Gated source tick; slow mode stops every high-speed tap.
  function automatic logic src_tick(
    input logic [2:0] sel,
    input logic dv,
    input logic slow,
    input logic [PRE_W-1:0] pre,
    input logic ls8,
    input logic ls,
    input logic fast_ok
  );
    logic t;
    t = 1'b0;
    case (sel)
      CLK_DIV11_OR_LS8: t = (dv || slow) ? ls8 : (&pre[DIV11_MSB:0]);
      CLK_DIV7: t = !slow && (&pre[DIV7_MSB:0]);
      CLK_DIV5: t = !slow && (&pre[DIV5_MSB:0]);
      CLK_DIV3: t = !slow && (&pre[DIV3_MSB:0]);
      CLK_LS: t = fast_ok && ls;
      CLK_HALF: t = fast_ok && !slow && pre[0];
      CLK_FULL: t = fast_ok && !slow;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // Register read multiplexer.
  function automatic logic [31:0] read_mux(input logic [4:0] addr);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (addr)
      ADDR_CTRL_LO: v[7:0] = ctrl_q[0];
      ADDR_CTRL_HI: v[7:0] = ctrl_q[1];
      ADDR_DUTY_LO: v[7:0] = duty_act_q[0]; // [R8]
      ADDR_DUTY_HI: v[7:0] = duty_act_q[1]; // [R8]
      ADDR_PCMP_LO: v[7:0] = pcmp_lo_q;
      ADDR_PCMP_HI: v[7:0] = pcmp_hi_q;
      ADDR_STATUS: begin
        v[STAT_CNT_LO_LSB +: 8] = cnt_q[0];
        v[STAT_CNT_HI_LSB +: 8] = cnt_q[1];
        v[STAT_FF_LO_BIT] = ff_q[0];
        v[STAT_FF_HI_BIT] = ff_q[1];
      end
      ADDR_POWER: v[1:0] = pwr_q;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // Tick generation and run decode.
  always_comb begin
    ls8_tick = low_speed_tick && (&ls_div_q);
    run16 = (ctrl_q[1][CTRL_MODE_MSB:CTRL_MODE_LSB] == MODE_TIMER16) && ctrl_q[1][CTRL_START_BIT];
    tick16 = src_tick(ctrl_q[0][CTRL_CLK_MSB:CTRL_CLK_LSB], pwr_q[PWR_DV_BIT],
                      pwr_q[PWR_SLOW_BIT], pre_q, ls8_tick, low_speed_tick, 1'b0); // [R20] [R21]
    for (int j = 0; j < 2; j++) begin
      // The cascade owns both counters, so a PWM start on the lower half waits until it stops.
      pwm_run[j] = (ctrl_q[j][CTRL_MODE_MSB:CTRL_MODE_LSB] == MODE_PWM8)
                   && ctrl_q[j][CTRL_START_BIT] && !run16;
      tick[j] = src_tick(ctrl_q[j][CTRL_CLK_MSB:CTRL_CLK_LSB], pwr_q[PWR_DV_BIT],
                         pwr_q[PWR_SLOW_BIT], pre_q, ls8_tick, low_speed_tick, 1'b1); // [R13]
    end
  end

  // Avalon slave: one wait cycle, then the access completes with waitrequest low.
  always_comb begin
    wait_d = !((avs_read || avs_write) && wait_q);
    rdata_d = rdata_q;
    if (avs_read && wait_q) begin
      rdata_d = read_mux(avs_address);
    end
    wr_lane = avs_write && !wait_q && avs_byteenable[0];
    wr_byte = avs_writedata[7:0];
    wr_ctrl[0] = wr_lane && (avs_address == ADDR_CTRL_LO);
    wr_ctrl[1] = wr_lane && (avs_address == ADDR_CTRL_HI);
    wr_duty[0] = wr_lane && (avs_address == ADDR_DUTY_LO);
    wr_duty[1] = wr_lane && (avs_address == ADDR_DUTY_HI);
    ctrl_d = ctrl_q;
    duty_buf_d = duty_buf_q;
    pcmp_lo_d = pcmp_lo_q;
    pcmp_hi_d = pcmp_hi_q;
    pwr_d = pwr_q;
    for (int j = 0; j < 2; j++) begin
      if (wr_ctrl[j]) begin
        ctrl_d[j] = wr_byte;
      end
      if (wr_duty[j]) begin
        duty_buf_d[j] = wr_byte; // [R6]
      end
    end
    // The compare bytes are used as soon as they land, so a half-written pair is live.
    if (wr_lane && (avs_address == ADDR_PCMP_LO)) begin
      pcmp_lo_d = wr_byte; // [R18]
    end
    if (wr_lane && (avs_address == ADDR_PCMP_HI)) begin
      pcmp_hi_d = wr_byte; // [R18]
    end
    if (wr_lane && (avs_address == ADDR_POWER)) begin
      pwr_d = wr_byte[1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      ctrl_q <= {CTRL_RESET, CTRL_RESET};
      duty_buf_q <= {DUTY_RESET, DUTY_RESET};
      pcmp_lo_q <= PCMP_RESET;
      pcmp_hi_q <= PCMP_RESET;
      pwr_q <= PWR_RESET;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      duty_buf_q <= duty_buf_d;
      pcmp_lo_q <= pcmp_lo_d;
      pcmp_hi_q <= pcmp_hi_d;
      pwr_q <= pwr_d;
    end
  end

  // Counters, output flip-flops and interrupt pulses.
  always_comb begin
    logic [15:0] nxt16;
    logic [7:0] nxt8;
    nxt16 = {cnt_q[1], cnt_q[0]} + 16'h0001;
    nxt8 = 8'h00;
    pre_d = pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
    ls_div_d = low_speed_tick ? ls_div_q + {{(LS_DIV_W-1){1'b0}}, 1'b1} : ls_div_q;
    cnt_d = cnt_q;
    ff_d = ff_q;
    irq_d = 2'b00;
    duty_act_d = duty_act_q;
    for (int j = 0; j < 2; j++) begin
      nxt8 = cnt_q[j] + 8'h01;
      if (pwm_run[j] && tick[j]) begin // [R1]
        if (cnt_q[j] == CNT_MAX) begin
          cnt_d[j] = 8'h00; // [R22]
          ff_d[j] = !ff_q[j]; // [R3]
          irq_d[j] = 1'b1; // [R3]
          duty_act_d[j] = duty_buf_q[j]; // [R6]
        end else begin
          cnt_d[j] = nxt8;
          if (nxt8 == duty_act_q[j]) begin
            ff_d[j] = !ff_q[j]; // [R2]
          end
        end
      end else if (!pwm_run[j] && !run16) begin
        cnt_d[j] = 8'h00;
      end
      // A write that stops the timer must not also reload the flip-flop.
      if (wr_ctrl[j] && !ctrl_q[j][CTRL_START_BIT]) begin
        ff_d[j] = wr_byte[CTRL_FF_BIT]; // [R4] [R11]
      end
      if (wr_duty[j] && !pwm_run[j]) begin
        duty_act_d[j] = wr_byte; // [R7]
      end
    end
    if (run16 && tick16) begin
      if (nxt16 == {pcmp_hi_q, pcmp_lo_q}) begin
        cnt_d[0] = 8'h00; // [R15]
        cnt_d[1] = 8'h00; // [R15]
        irq_d[1] = 1'b1; // [R15]
      end else begin
        cnt_d[0] = nxt16[7:0];
        cnt_d[1] = nxt16[15:8];
      end
    end
    // Stopped timers leave ff_q untouched until a control write loads the initial-value bit, so the pin keeps its level.
    pin_d = ~ff_d; // [R5] [R10]
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pre_q <= '0;
      ls_div_q <= '0;
      cnt_q <= '0;
      duty_act_q <= {DUTY_RESET, DUTY_RESET};
      ff_q <= 2'b00; // [R4]
      irq_q <= 2'b00;
      pin_q <= PIN_RESET;
    end else begin
      pre_q <= pre_d;
      ls_div_q <= ls_div_d;
      cnt_q <= cnt_d;
      duty_act_q <= duty_act_d;
      ff_q <= ff_d;
      irq_q <= irq_d;
      pin_q <= pin_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign pwm_out_pin = pin_q;
  assign timer_irq = irq_q;

endmodule

/* tpwm_timer_props.sv */
// Port-level checks for the dual PWM / 16-bit timer.
// Assumes binding into tpwm_timer; sees only its ports.
`timescale 1ns/1ps
module tpwm_timer_props
  import tpwm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic low_speed_tick,
  input wire logic [1:0] pwm_out_pin,
  input wire logic [1:0] timer_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_wait_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  property p_rd_upper;
    avs_read && !avs_waitrequest && avs_address != ADDR_STATUS |-> avs_readdata[31:8] == 24'h0;
  endproperty
  property p_rd_stand; !(avs_read && !avs_waitrequest) |-> $stable(avs_readdata); endproperty
  property p_pin_rst; $fell(rst) |-> pwm_out_pin == 2'h3; endproperty
  property p_irq0; timer_irq[0] |=> !timer_irq[0] [*8]; endproperty
  property p_irq1; timer_irq[1] |=> !timer_irq[1] [*4]; endproperty
  property p_irq_pin; timer_irq[0] |-> pwm_out_pin[0] != $past(pwm_out_pin[0]); endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low too long");
  a_wait_ans: assert property (p_wait_ans) else $error("no bus answer");
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  a_rd_stand: assert property (p_rd_stand) else $error("read data moved");
  a_pin_rst: assert property (p_pin_rst) else $error("pin not high after reset");
  a_irq0: assert property (p_irq0) else $error("lower irq too close");
  a_irq1: assert property (p_irq1) else $error("upper irq too close");
  a_irq_pin: assert property (p_irq_pin) else $error("no pin toggle at overflow");
  c_irq0: cover property (timer_irq[0]);
  c_irq1: cover property (timer_irq[1]);
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule
bind tpwm_timer tpwm_timer_props u_props (.core_clk, .rst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .low_speed_tick,
  .pwm_out_pin, .timer_irq);

/* tpwm_timer_tb.sv */
// Self-checking bench for the dual PWM / 16-bit timer.
// Assumes tpwm_timer and its bound checker are compiled first.
`timescale 1ns/1ps
module tpwm_timer_tb
  import tpwm_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic low_speed_tick = 1'b0;
  logic [1:0] pwm_out_pin;
  logic [1:0] timer_irq;
  logic [1:0] ls_cnt = 2'h0;
  logic [7:0] rdat;
  logic [2:0] sels [5] = '{CLK_DIV11_OR_LS8, CLK_DIV5, CLK_DIV3, CLK_LS, CLK_HALF};
  int pers [5] = '{8192, 8192, 2048, 1024, 512};
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  tpwm_timer uut (.core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .low_speed_tick, .pwm_out_pin,
    .timer_irq);
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // The low-speed tick comes every fourth cycle, so low/8 is one tick in 32 cycles.
  always @(posedge core_clk) begin
    ls_cnt <= ls_cnt + 2'h1;
    low_speed_tick <= (ls_cnt == 2'h3);
    cyc++;
    // The tests need about 50000 cycles; the ceiling leaves slack for the slowest clock.
    if (cyc == 70000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wait_irq(input int i);
    n = 0;
    do begin @(posedge core_clk); n++; end while (timer_irq[i] !== 1'b1);
  endtask
  task automatic wait_pin(input logic v);
    n = 0;
    do begin @(posedge core_clk); n++; end while (pwm_out_pin[0] !== v);
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk("pin reset", 16'h0003, {14'h0, pwm_out_pin});
    bus(1'b0, 5'h02, 8'h00);
    chk("unmapped", 16'h0000, {8'h0, rdat});
    bus(1'b1, ADDR_DUTY_LO, 8'h40);
    bus(1'b0, ADDR_DUTY_LO, 8'h00);
    chk("duty stopped", 16'h0040, {8'h0, rdat});
    bus(1'b1, ADDR_CTRL_LO, 8'h62);
    bus(1'b1, ADDR_CTRL_LO, 8'h6A);
    wait_irq(0);
    chk("pin overflow", 16'h0001, {15'h0, pwm_out_pin[0]});
    wait_pin(1'b0);
    chk("match delay", 16'h0040, 16'(n));
    wait_irq(0);
    chk("rest of period", 16'h00C0, 16'(n));
    bus(1'b1, ADDR_DUTY_LO, 8'h80);
    bus(1'b0, ADDR_DUTY_LO, 8'h00);
    chk("duty old", 16'h0040, {8'h0, rdat});
    wait_irq(0);
    wait_pin(1'b0);
    chk("new match delay", 16'h0080, 16'(n));
    bus(1'b0, ADDR_DUTY_LO, 8'h00);
    chk("duty new", 16'h0080, {8'h0, rdat});
    bus(1'b1, ADDR_CTRL_LO, 8'h62);
    repeat (300) @(posedge core_clk);
    chk("pin held", 16'h0000, {15'h0, pwm_out_pin[0]});
    bus(1'b1, ADDR_CTRL_LO, 8'h62);
    repeat (2) @(posedge core_clk);
    chk("pin from init bit", 16'h0001, {15'h0, pwm_out_pin[0]});
    bus(1'b1, ADDR_CTRL_LO, 8'hE2);
    repeat (2) @(posedge core_clk);
    chk("pin from set init bit", 16'h0000, {15'h0, pwm_out_pin[0]});
    // A reset with the timer stopped must clear the flip-flop that software has just set.
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk("pin after mid reset", 16'h0003, {14'h0, pwm_out_pin});
    repeat (2) @(posedge core_clk);
    chk("pin settled after reset", 16'h0003, {14'h0, pwm_out_pin});
    bus(1'b1, ADDR_POWER, 8'h01);
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, ADDR_CTRL_LO, {1'b0, sels[k], 4'h2});
      bus(1'b1, ADDR_CTRL_LO, {1'b0, sels[k], 4'hA});
      wait_irq(0);
      wait_irq(0);
      chk("clock period", 16'(pers[k]), 16'(n));
    end
    bus(1'b1, ADDR_CTRL_LO, 8'h00);
    bus(1'b1, ADDR_PCMP_LO, 8'h02);
    bus(1'b1, ADDR_PCMP_HI, 8'h01);
    bus(1'b1, ADDR_CTRL_LO, {1'b0, CLK_DIV3, 4'h0});
    bus(1'b1, ADDR_CTRL_HI, {5'h00, MODE_TIMER16});
    bus(1'b1, ADDR_CTRL_HI, {5'h01, MODE_TIMER16});
    wait_irq(1);
    wait_irq(1);
    chk("timer16 period", 16'h0810, 16'(n));
    bus(1'b1, ADDR_CTRL_HI, {5'h00, MODE_TIMER16});
    bus(1'b1, ADDR_PCMP_LO, 8'h03);
    bus(1'b1, ADDR_PCMP_HI, 8'h00);
    bus(1'b1, ADDR_CTRL_LO, {1'b0, CLK_DIV7, 4'h0});
    bus(1'b1, ADDR_CTRL_HI, {5'h01, MODE_TIMER16});
    wait_irq(1);
    wait_irq(1);
    chk("timer16 div7 period", 16'h0180, 16'(n));
    bus(1'b1, ADDR_CTRL_HI, {5'h00, MODE_TIMER16});
    bus(1'b1, ADDR_POWER, 8'h00);
    bus(1'b1, ADDR_PCMP_LO, 8'h01);
    bus(1'b1, ADDR_PCMP_HI, 8'h00);
    bus(1'b1, ADDR_CTRL_LO, {1'b0, CLK_DIV11_OR_LS8, 4'h0});
    bus(1'b1, ADDR_CTRL_HI, {5'h01, MODE_TIMER16});
    wait_irq(1);
    wait_irq(1);
    chk("timer16 div11 period", 16'h0800, 16'(n));
    bus(1'b1, ADDR_CTRL_HI, {5'h00, MODE_TIMER16});
    bus(1'b1, ADDR_POWER, 8'h02);
    bus(1'b1, ADDR_CTRL_LO, {1'b0, CLK_DIV3, 4'h0});
    bus(1'b1, ADDR_CTRL_HI, {5'h01, MODE_TIMER16});
    repeat (100) @(posedge core_clk);
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk("slow mode count", 16'h0000, {8'h0, rdat});
    report_and_stop();
  end
endmodule
